// File: hdl/flash_op_engine.sv
`timescale 1ns/1ps
`include "nvm_params.svh"

module flash_op_engine #(
  parameter int ROW_WORDS = `ROW_WORDS,
  parameter int ROW_BYTES = `ROW_BYTES,
  parameter int PAGE_BYTES = `PAGE_BYTES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // request side
  flash_op_if.eng          op_if,
  // flash array
  output logic             flash_req_o,
  output logic [1:0]       flash_cmd_o,
  output logic [31:0]      flash_addr_o,
  output logic [31:0]      flash_wdata_o,
  input  wire logic        flash_ack_i,
  // system sram
  output logic             sram_rd_o,
  output logic [31:0]      sram_addr_o,
  input  wire logic        sram_rvalid_i,
  input  wire logic [31:0] sram_rdata_i
);

  localparam int CW = $clog2(ROW_WORDS);
  localparam int ROW_LSB = $clog2(ROW_BYTES);
  localparam int PAGE_LSB = $clog2(PAGE_BYTES);
  localparam logic [CW-1:0] LAST_WORD = CW'(ROW_WORDS - 1);

  nvm_pkg::eng_state_t state_r;
  logic [CW-1:0]       cnt_r;
  logic                is_row_r;
  logic                done_r;
  logic                err_r;

  wire last_beat = ~is_row_r | (cnt_r == LAST_WORD);

  assign op_if.done = done_r;
  assign op_if.err  = err_r;

  // ************************************************************
  // operation sequencer
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r       <= nvm_pkg::ENG_IDLE;
      cnt_r         <= '0;
      is_row_r      <= 1'b0;
      done_r        <= 1'b0;
      err_r         <= 1'b0;
      flash_req_o   <= 1'b0;
      flash_cmd_o   <= 2'h0;
      flash_addr_o  <= `WORD_RST;
      flash_wdata_o <= `WORD_RST;
      sram_rd_o     <= 1'b0;
      sram_addr_o   <= `WORD_RST;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        nvm_pkg::ENG_IDLE: if (op_if.start) begin
          err_r    <= 1'b0;
          cnt_r    <= '0;
          is_row_r <= 1'b0;
          if (op_if.deny) begin
            err_r   <= 1'b1;
            state_r <= nvm_pkg::ENG_FIN;
          end else begin
            unique case (op_if.op)
              `OP_WORD: begin
                flash_req_o   <= 1'b1;
                flash_cmd_o   <= 2'(nvm_pkg::CMD_PROGRAM);
                flash_addr_o  <= {op_if.addr[31:2], 2'h0};
                flash_wdata_o <= op_if.data;
                state_r       <= nvm_pkg::ENG_ISSUE;
              end
              `OP_ROW: begin
                is_row_r     <= 1'b1;
                sram_rd_o    <= 1'b1;
                sram_addr_o  <= {op_if.src[31:2], 2'h0};
                flash_addr_o <= {op_if.addr[31:ROW_LSB], ROW_LSB'(0)};
                state_r      <= nvm_pkg::ENG_FETCH;
              end
              `OP_PAGE: begin
                flash_req_o  <= 1'b1;
                flash_cmd_o  <= 2'(nvm_pkg::CMD_ERASE_PAGE);
                flash_addr_o <= {op_if.addr[31:PAGE_LSB], PAGE_LSB'(0)};
                state_r      <= nvm_pkg::ENG_ISSUE;
              end
              `OP_REGION: begin
                flash_req_o  <= 1'b1;
                flash_cmd_o  <= 2'(nvm_pkg::CMD_ERASE_REGION);
                flash_addr_o <= `WORD_RST;
                state_r      <= nvm_pkg::ENG_ISSUE;
              end
              default: begin
                // unknown codes finish at once, flagged, so start clears
                err_r   <= 1'b1;
                state_r <= nvm_pkg::ENG_FIN;
              end
            endcase
          end
        end
        nvm_pkg::ENG_FETCH: if (sram_rvalid_i) begin
          sram_rd_o     <= 1'b0;
          flash_wdata_o <= sram_rdata_i;
          flash_cmd_o   <= 2'(nvm_pkg::CMD_PROGRAM);
          flash_req_o   <= 1'b1;
          state_r       <= nvm_pkg::ENG_ISSUE;
        end
        nvm_pkg::ENG_ISSUE: if (flash_ack_i) begin
          flash_req_o <= 1'b0;
          if (last_beat) begin
            state_r <= nvm_pkg::ENG_FIN;
          end else begin
            cnt_r        <= cnt_r + 1'b1;
            flash_addr_o <= flash_addr_o + 32'h0000_0004;
            sram_addr_o  <= sram_addr_o + 32'h0000_0004;
            sram_rd_o    <= 1'b1;
            state_r      <= nvm_pkg::ENG_FETCH;
          end
        end
        nvm_pkg::ENG_FIN: begin
          done_r  <= 1'b1;
          state_r <= nvm_pkg::ENG_IDLE;
        end
      endcase
    end
  end

endmodule // flash_op_engine

// File: hdl/flash_op_if.sv
`timescale 1ns/1ps
interface flash_op_if;
  logic        start;
  logic [3:0]  op;
  logic        deny;
  logic [31:0] addr;
  logic [31:0] data;
  logic [31:0] src;
  logic        done;
  logic        err;

  modport ctl (output start, op, deny, addr, data, src, input done, err);
  modport eng (input start, op, deny, addr, data, src, output done, err);
endinterface

// File: hdl/nvm_params.svh
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFF_CTRL      12'h000
`define OFF_CTRL_SET  12'h004
`define OFF_CTRL_CLR  12'h008
`define OFF_KEY       12'h010
`define OFF_ADDR      12'h020
`define OFF_DATA      12'h030
`define OFF_SRC       12'h040

// ************************************************************
// control register fields and reset values
// ************************************************************
`define CTRL_START    15
`define CTRL_WRITE_ENABLE_BIT     14
`define CTRL_WRITE_ERROR_FLAG    13
`define CTRL_LOW_VOLTAGE_ERROR_FLAG   12
`define CTRL_LOW_VOLTAGE_STATUS_BIT  11
`define CTRL_OP_MSB   3
`define CTRL_OP_LSB   0
`define CTRL_RST      32'h0000_0000
`define WORD_RST      32'h0000_0000

// ************************************************************
// unlock keys and operation codes
// ************************************************************
`define KEY_FIRST     32'hAA99_6655
`define KEY_SECOND    32'h5566_99AA
`define OP_WORD       4'h1
`define OP_ROW        4'h3
`define OP_PAGE       4'h4
`define OP_REGION     4'h5

// ************************************************************
// array geometry
// ************************************************************
`define ROW_WORDS     128
`define ROW_BYTES     512
`define ROWS_PER_PAGE 8
`define PAGE_BYTES    (`ROW_BYTES * `ROWS_PER_PAGE)
`define PROG_PAGES    16

`endif

// File: hdl/nvm_pkg.sv
package nvm_pkg;

  typedef enum logic [1:0] {
    LOCKED,
    KEY1_SEEN,
    UNLOCKED
  } unlock_state_t;

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_FETCH,
    ENG_ISSUE,
    ENG_FIN
  } eng_state_t;

  typedef enum logic [1:0] {
    CMD_PROGRAM,
    CMD_ERASE_PAGE,
    CMD_ERASE_REGION
  } flash_cmd_t;

endpackage

// File: hdl/nvm_unlock_program_erase_sequencer.sv
`timescale 1ns/1ps
`include "nvm_params.svh"

// Summary of operation
// - rows of 128 words, eight rows a page
// - program one word or one row
// - stall flash fetches while operation runs
// - ram fetches continue unstalled
// - start writable only with write enable
// - unlock lapses after one bus access
// - two key writes then start set
// - wrong order leaves start clear
// - software checks error flags afterwards
// - hardware clears start on completion
// - word program writes data register
// - row program fetches row from sram
// - row program ignores sub-row address bits
// - page erase ignores sub-page address bits
// - erase only unprotected pages
// - region erase needs no protected page
// - program and boot regions, debug page
// - region erase ignores the address
// - device reset clears enable, status, unlock
// - sleep deferred while operation runs
// - unlock held in debug mode
module nvm_unlock_program_erase_sequencer #(
  parameter int          PROG_PAGES = `PROG_PAGES,
  parameter logic [31:0] PROG_BASE  = 32'h0000_0000,
  parameter logic [31:0] BOOT_BASE  = 32'h1000_0000,
  parameter logic [31:0] BOOT_MASK  = 32'hFFFF_C000
) (
  // clock and resets
  input  wire logic                  MCLK_I,
  input  wire logic                  RSTN_I,
  input  wire logic                  DEV_RSTN_I,
  // apb slave
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic [11:0]           PADDR_I,
  input  wire logic [31:0]           PWDATA_I,
  output logic                       PREADY_O,
  output logic [31:0]                PRDATA_O,
  output logic                       PSLVERR_O,
  // system
  input  wire logic                  DEBUG_I,
  input  wire logic                  SLEEP_REQ_I,
  output logic                       SLEEP_OK_O,
  output logic                       FETCH_STALL_O,
  output logic                       DONE_EVT_O,
  // write protection configuration
  input  wire logic                  BOOT_WP_I,
  input  wire logic [PROG_PAGES-1:0] PROG_WP_I,
  // low voltage detector
  output logic                       LVD_EN_O,
  input  wire logic                  LVD_FAULT_I,
  // flash array
  output logic                       FLASH_REQ_O,
  output logic [1:0]                 FLASH_CMD_O,
  output logic [31:0]                FLASH_ADDR_O,
  output logic [31:0]                FLASH_WDATA_O,
  input  wire logic                  FLASH_ACK_I,
  // system sram
  output logic                       SRAM_RD_O,
  output logic [31:0]                SRAM_ADDR_O,
  input  wire logic                  SRAM_RVALID_I,
  input  wire logic [31:0]           SRAM_RDATA_I
);

  localparam int PAGE_LSB = $clog2(`PAGE_BYTES);
  localparam int PIW = (PROG_PAGES > 1) ? $clog2(PROG_PAGES) : 1;

  // ************************************************************
  // functions
  // ************************************************************
  // applies a plain, set-alias or clear-alias write to a word
  function automatic logic [31:0] alias_apply(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic set,
                                              input logic clr);
    alias_apply = set ? (old | wd) : (clr ? (old & ~wd) : wd);
  endfunction

  // page number inside a region of the given base
  function automatic logic [PIW-1:0] page_of(input logic [31:0] a,
                                             input logic [31:0] base);
    logic [31:0] off;
    off = a - base;
    page_of = off[PAGE_LSB +: PIW];
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  nvm_pkg::unlock_state_t unlock_r;
  logic        pready_r;
  logic        start_r;
  logic        write_enable_bit_r;
  logic        write_error_flag_r;
  logic        low_voltage_error_flag_r;
  logic        low_voltage_status_bit_r;
  logic [3:0]  op_r;
  logic [31:0] addr_r;
  logic [31:0] data_r;
  logic [31:0] src_r;
  logic        lvd_meta_r;
  logic        lvd_sync_r;
  logic        op_start_r;
  logic        deny_r;

  flash_op_if op_if ();

  // ************************************************************
  // bus decode
  // ************************************************************
  wire access   = PSEL_I & PENABLE_I & pready_r;
  wire wr       = access & PWRITE_I;
  wire hit_ctrl = (PADDR_I == `OFF_CTRL);
  wire hit_set  = (PADDR_I == `OFF_CTRL_SET);
  wire hit_clr  = (PADDR_I == `OFF_CTRL_CLR);
  wire hit_key  = (PADDR_I == `OFF_KEY);
  wire hit_addr = (PADDR_I == `OFF_ADDR);
  wire hit_data = (PADDR_I == `OFF_DATA);
  wire hit_src  = (PADDR_I == `OFF_SRC);
  wire hit_any  = hit_ctrl | hit_set | hit_clr | hit_key
                | hit_addr | hit_data | hit_src;

  wire [31:0] ctrl_word = {16'h0000, start_r, write_enable_bit_r, write_error_flag_r, low_voltage_error_flag_r,
                           low_voltage_status_bit_r, 7'h00, op_r};
  wire [31:0] ctrl_new  = alias_apply(ctrl_word, PWDATA_I, hit_set,
                                      hit_clr);
  wire        ctrl_wr   = wr & (hit_ctrl | hit_set | hit_clr);
  wire        key_wr    = wr & hit_key;

  wire [31:0] rd_mux = hit_ctrl | hit_set | hit_clr ? ctrl_word :
                       hit_addr ? addr_r :
                       hit_data ? data_r :
                       hit_src  ? src_r  : 32'h0000_0000;

  // ************************************************************
  // start qualification
  // ************************************************************
  wire start_req = ctrl_wr & ctrl_new[`CTRL_START] & ~start_r
                 & write_enable_bit_r
                 & (unlock_r == nvm_pkg::UNLOCKED);

  wire done = op_if.done;

  // protection lookup: the last boot page belongs to the debugger
  wire in_boot   = ((addr_r & BOOT_MASK) == BOOT_BASE);
  wire boot_last = &addr_r[PAGE_LSB +: 2];
  wire prog_prot = PROG_WP_I[page_of(addr_r, PROG_BASE)];
  wire page_prot = in_boot ? (BOOT_WP_I | (boot_last & ~DEBUG_I))
                           : prog_prot;
  wire deny_w    = (op_r == `OP_REGION) ? (|PROG_WP_I)
                                        : page_prot;

  // ************************************************************
  // apb response
  // ************************************************************
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      pready_r  <= 1'b0;
      PRDATA_O  <= `WORD_RST;
      PSLVERR_O <= 1'b0;
    end else begin
      // one wait state keeps every answer registered
      pready_r <= PSEL_I & PENABLE_I & ~pready_r;
      if (PSEL_I & PENABLE_I & ~pready_r) begin
        PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_mux;
        PSLVERR_O <= ~hit_any;
      end
    end
  end

  assign PREADY_O = pready_r;

  // ************************************************************
  // unlock sequence
  // ************************************************************
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I || !DEV_RSTN_I) begin
      unlock_r <= nvm_pkg::LOCKED;
    end else if (access) begin
      unique case (unlock_r)
        nvm_pkg::LOCKED:
          if (key_wr && PWDATA_I == `KEY_FIRST) begin
            unlock_r <= nvm_pkg::KEY1_SEEN;
          end
        nvm_pkg::KEY1_SEEN:
          if (key_wr && PWDATA_I == `KEY_SECOND) begin
            unlock_r <= nvm_pkg::UNLOCKED;
          end else if (!DEBUG_I || key_wr) begin
            unlock_r <= nvm_pkg::LOCKED;
          end
        nvm_pkg::UNLOCKED:
          // any access lapses it, except idle debug steps
          if (!DEBUG_I || ctrl_wr || key_wr) begin
            unlock_r <= nvm_pkg::LOCKED;
          end
        default: unlock_r <= nvm_pkg::LOCKED;
      endcase
    end
  end

  // ************************************************************
  // control register
  // ************************************************************
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      start_r   <= 1'b0;
      write_error_flag_r   <= 1'b0;
      low_voltage_error_flag_r  <= 1'b0;
      op_r      <= 4'h0;
      addr_r    <= `WORD_RST;
      data_r    <= `WORD_RST;
      src_r     <= `WORD_RST;
    end else begin
      if (start_req) begin
        start_r <= 1'b1;
      end else if (done) begin
        start_r <= 1'b0;
      end
      // hardware set wins over a software write in the same cycle
      if (done && op_if.err) begin
        write_error_flag_r <= 1'b1;
      end else if (ctrl_wr) begin
        write_error_flag_r <= ctrl_new[`CTRL_WRITE_ERROR_FLAG];
      end
      if (start_r && lvd_sync_r) begin
        low_voltage_error_flag_r <= 1'b1;
      end else if (ctrl_wr) begin
        low_voltage_error_flag_r <= ctrl_new[`CTRL_LOW_VOLTAGE_ERROR_FLAG];
      end
      // target registers freeze while an operation runs
      if (ctrl_wr && !start_r) begin
        op_r <= ctrl_new[`CTRL_OP_MSB:`CTRL_OP_LSB];
      end
      if (wr && hit_addr && !start_r) begin
        addr_r <= PWDATA_I;
      end
      if (wr && hit_data && !start_r) begin
        data_r <= PWDATA_I;
      end
      if (wr && hit_src && !start_r) begin
        src_r <= PWDATA_I;
      end
    end
  end

  // write enable and detector status also clear on device reset
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I || !DEV_RSTN_I) begin
      write_enable_bit_r    <= 1'b0;
      low_voltage_status_bit_r <= 1'b0;
    end else begin
      if (ctrl_wr && !start_r) begin
        write_enable_bit_r <= ctrl_new[`CTRL_WRITE_ENABLE_BIT];
      end
      low_voltage_status_bit_r <= write_enable_bit_r & lvd_sync_r;
    end
  end

  // ************************************************************
  // detector, stall, sleep and event outputs
  // ************************************************************
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      lvd_meta_r    <= 1'b0;
      lvd_sync_r    <= 1'b0;
      LVD_EN_O      <= 1'b0;
      FETCH_STALL_O <= 1'b0;
      SLEEP_OK_O    <= 1'b0;
      DONE_EVT_O    <= 1'b0;
      op_start_r    <= 1'b0;
      deny_r        <= 1'b0;
    end else begin
      lvd_meta_r    <= LVD_FAULT_I;
      lvd_sync_r    <= lvd_meta_r;
      LVD_EN_O      <= ctrl_wr && !start_r ? ctrl_new[`CTRL_WRITE_ENABLE_BIT]
                                           : write_enable_bit_r;
      // only flash fetches are held; ram fetches bypass this
      FETCH_STALL_O <= start_req | (start_r & ~done);
      SLEEP_OK_O    <= SLEEP_REQ_I & ~start_r & ~start_req;
      DONE_EVT_O    <= done;
      op_start_r    <= start_req;
      if (start_req) begin
        deny_r <= deny_w;
      end
    end
  end

  assign op_if.start = op_start_r;
  assign op_if.op    = op_r;
  assign op_if.deny  = deny_r;
  assign op_if.addr  = addr_r;
  assign op_if.data  = data_r;
  assign op_if.src   = src_r;

  // ************************************************************
  // operation engine
  // ************************************************************
  flash_op_engine #(
    .ROW_WORDS  (`ROW_WORDS),
    .ROW_BYTES  (`ROW_BYTES),
    .PAGE_BYTES (`PAGE_BYTES)
  ) u_engine (
    .clk_i         (MCLK_I),
    .rst_n_i       (RSTN_I),
    .op_if         (op_if),
    .flash_req_o   (FLASH_REQ_O),
    .flash_cmd_o   (FLASH_CMD_O),
    .flash_addr_o  (FLASH_ADDR_O),
    .flash_wdata_o (FLASH_WDATA_O),
    .flash_ack_i   (FLASH_ACK_I),
    .sram_rd_o     (SRAM_RD_O),
    .sram_addr_o   (SRAM_ADDR_O),
    .sram_rvalid_i (SRAM_RVALID_I),
    .sram_rdata_i  (SRAM_RDATA_I)
  );

endmodule // nvm_unlock_program_erase_sequencer

// File: testbench/nvm_seq_assertions.sv
`timescale 1ns/1ps
module nvm_seq_assertions (
  // clock and reset
  input wire logic        MCLK_I,
  input wire logic        RSTN_I,
  // apb
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PREADY_O,
  // status
  input wire logic        SLEEP_OK_O,
  input wire logic        FETCH_STALL_O,
  input wire logic        DONE_EVT_O,
  // flash and sram
  input wire logic        FLASH_REQ_O,
  input wire logic [1:0]  FLASH_CMD_O,
  input wire logic [31:0] FLASH_ADDR_O,
  input wire logic        FLASH_ACK_I,
  input wire logic        SRAM_RD_O
);
  // ************************************************************
  // sequencer checks
  // ************************************************************
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  ready_wait_a: assert property (
    PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("apb answer not in second access cycle");
  stall_on_req_a: assert property (FLASH_REQ_O |-> FETCH_STALL_O)
    else $error("flash command without fetch stall");
  stall_on_sram_a: assert property (SRAM_RD_O |-> FETCH_STALL_O)
    else $error("row fetch without fetch stall");
  done_pulse_a: assert property (DONE_EVT_O |=> !DONE_EVT_O)
    else $error("completion event longer than one cycle");
  done_at_end_a: assert property (
    $fell(FETCH_STALL_O) |-> DONE_EVT_O)
    else $error("stall ended without completion event");
  req_hold_a: assert property (FLASH_REQ_O && !FLASH_ACK_I |=>
    FLASH_REQ_O && $stable(FLASH_ADDR_O) && $stable(FLASH_CMD_O))
    else $error("flash command changed before ack");
  region_addr_a: assert property (
    FLASH_REQ_O && FLASH_CMD_O == 2'h2 |-> FLASH_ADDR_O == 32'h0000_0000)
    else $error("region erase carries an address");
  page_align_a: assert property (
    FLASH_REQ_O && FLASH_CMD_O == 2'h1 |-> FLASH_ADDR_O[11:0] == 12'h000)
    else $error("page erase address not page aligned");
  sleep_defer_a: assert property (SLEEP_OK_O |-> !FETCH_STALL_O)
    else $error("sleep granted while operation runs");
endmodule // nvm_seq_assertions

bind nvm_unlock_program_erase_sequencer nvm_seq_assertions chk_i (
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PREADY_O(PREADY_O), .SLEEP_OK_O(SLEEP_OK_O), .DONE_EVT_O(DONE_EVT_O),
  .FETCH_STALL_O(FETCH_STALL_O), .FLASH_REQ_O(FLASH_REQ_O),
  .FLASH_CMD_O(FLASH_CMD_O), .FLASH_ADDR_O(FLASH_ADDR_O),
  .FLASH_ACK_I(FLASH_ACK_I), .SRAM_RD_O(SRAM_RD_O));

// File: testbench/test_nvm_unlock_program_erase_sequencer.sv
`timescale 1ns/1ps
`include "nvm_params.svh"
module test_nvm_unlock_program_erase_sequencer;
  // ************************************************************
  // design and responders
  // ************************************************************
  logic        clk = 0, rstn = 0, dev_rstn = 1, psel = 0, pen = 0, pwr = 0;
  logic        sleep_req = 0, ack = 0, rvalid = 0, er, dbg = 0, bwp = 0;
  logic [11:0] paddr = 12'h000;
  logic [15:0] wp = 16'h0000;
  logic [31:0] pwdata = 32'h0, sdata = 32'h0, seed = 32'h0000_0061;
  logic [31:0] rr, rd, pa;
  logic [3:0]  ops [4] = '{`OP_WORD, `OP_ROW, `OP_PAGE, `OP_REGION};
  logic [33:0] ca_q[$];
  logic [31:0] wd_q[$];
  wire logic        pready, pslverr, sleep_ok, stall, done, lvd_en, freq, srd;
  wire logic [1:0]  fcmd;
  wire logic [31:0] prdata, faddr, fwd, saddr;
  int          n_mismatch = 0, tests_run = 0, n_done = 0;

  always #2 clk = ~clk;

  nvm_unlock_program_erase_sequencer nvm_unlock_program_erase_sequencer_i (
    .MCLK_I(clk), .RSTN_I(rstn), .DEV_RSTN_I(dev_rstn), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr),
    .DEBUG_I(dbg), .SLEEP_REQ_I(sleep_req), .SLEEP_OK_O(sleep_ok),
    .FETCH_STALL_O(stall), .DONE_EVT_O(done), .BOOT_WP_I(bwp),
    .PROG_WP_I(wp), .LVD_EN_O(lvd_en), .LVD_FAULT_I(1'b0),
    .FLASH_REQ_O(freq), .FLASH_CMD_O(fcmd), .FLASH_ADDR_O(faddr),
    .FLASH_WDATA_O(fwd), .FLASH_ACK_I(ack), .SRAM_RD_O(srd),
    .SRAM_ADDR_O(saddr), .SRAM_RVALID_I(rvalid), .SRAM_RDATA_I(sdata));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] sram_val(input logic [31:0] a);
    return a ^ 32'h5A5A_0F0F;
  endfunction

  function automatic logic [33:0] exp_ca(input logic [3:0] op,
                                         input logic [31:0] a, input int i);
    case (op)
      `OP_WORD: return {2'h0, a};
      `OP_ROW:  return {2'h0, a[31:9], 9'h000} + 34'(4 * i);
      `OP_PAGE: return {2'h1, a[31:12], 12'h000};
      default:  return {2'h2, 32'h0};
    endcase
  endfunction

  // random stalls on both the array and the sram side
  always @(posedge clk) begin
    rr = rnd();
    sleep_req <= rr[0];
    ack <= freq && !ack && rr[1];
    rvalid <= srd && !rvalid && rr[2];
    sdata <= sram_val(saddr);
    if (freq && ack) begin
      ca_q.push_back({fcmd, faddr});
      wd_q.push_back(fwd);
    end
    if (done) n_done++;
  end

  // ************************************************************
  // bus tasks and checks
  // ************************************************************
  task chk(input string what, input logic [33:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    // only the watchdog ends a wait for the answer
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // bad: 0 normal, 1 refused by protection, 2 unlock broken by a read,
  // 3 read between the keys in debug mode, which must not break it
  task run_op(input logic [3:0] op, input logic [31:0] a, d, s,
              input int bad);
    int n, d0;
    logic [33:0] ex;
    n = 0;
    d0 = n_done;
    wr(`OFF_ADDR, a);
    wr(`OFF_DATA, d);
    wr(`OFF_SRC, s);
    wr(`OFF_CTRL, {28'h0000400, op});
    wr(`OFF_KEY, `KEY_FIRST);
    if (bad >= 2) rdc(`OFF_CTRL);
    wr(`OFF_KEY, `KEY_SECOND);
    wr(`OFF_CTRL_SET, 32'h0000_8000);
    do rdc(`OFF_CTRL); while (rd[15] === 1'b1 && ++n < 900);
    ex = (bad == 1) ? 34'h6000 : 34'h4000;
    chk("control", 34'(rd & 32'h0000_E000), ex);
    chk("done events", 34'(n_done), 34'(d0 + (bad != 2)));
    wr(`OFF_CTRL_CLR, 32'h0000_6000);
    n = (bad == 1 || bad == 2) ? 0 : (op == `OP_ROW) ? 128 : 1;
    chk("commands", 34'(ca_q.size()), 34'(n));
    for (int i = 0; i < n; i++) begin
      chk("flash command", ca_q[i], exp_ca(op, a, i));
      if (op <= `OP_ROW) begin
        ex = 34'(op == `OP_WORD ? d : sram_val(s + 4 * i));
        chk("flash data", 34'(wd_q[i]), ex);
      end
    end
    ca_q.delete();
    wd_q.delete();
  endtask

  task wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    rdc(`OFF_CTRL);
    chk("control reset", 34'(rd), 34'(`CTRL_RST));
    rdc(12'h0FC);
    chk("unmapped read", {1'b0, er, rd}, 34'h1_0000_0000);
    // targets never hold the code that the bench would be running
    for (int k = 0; k < 8; k++)
      run_op(ops[k % 4], rnd() & 32'h0000_FFFC, rnd(),
             rnd() & 32'h0003_FFFC, 0);
    // one protected page refuses every kind of operation touching it
    pa = rnd() & 32'h0000_FFFC;
    wp <= 16'h0001 << pa[15:12];
    for (int k = 0; k < 4; k++)
      run_op(ops[k], pa, rnd(), rnd() & 32'h0003_FFFC, 1);
    wp <= 16'h0000;
    run_op(`OP_WORD, pa, rnd(), 32'h0, 2);
    // boot pages: protect bit, reserved debug page, then debug mode
    bwp <= 1;
    pa = 32'h1000_0000 | (rnd() & 32'h0000_3FFC);
    run_op(`OP_PAGE, pa, 32'h0, 32'h0, 1);
    bwp <= 0;
    pa = 32'h1000_3000 | (rnd() & 32'h0000_0FFC);
    run_op(`OP_WORD, pa, rnd(), 32'h0, 1);
    dbg <= 1;
    run_op(`OP_WORD, pa, rnd(), 32'h0, 3);
    dbg <= 0;
    wr(`OFF_CTRL, 32'h0000_4001);
    @(posedge clk);
    chk("detector enable", 34'(lvd_en), 34'h1);
    dev_rstn <= 0;
    @(posedge clk);
    dev_rstn <= 1;
    rdc(`OFF_CTRL);
    chk("control after device reset", 34'(rd), 34'h1);
    chk("detector off", 34'(lvd_en), 34'h0);
    wrap_up();
  end

  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
endmodule // test_nvm_unlock_program_erase_sequencer
